// >>> port_ctrl_pkg.sv
// Package for the per-port control register bank.
// Assumes an AHB-Lite slave with 32-bit data, one word per register.
package port_ctrl_pkg;

    localparam int num_ports = 5;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] port1_phy_control = 8'h1d;
    localparam logic [7:0] port2_phy_control = 8'h2d;
    localparam logic [7:0] port3_phy_control = 8'h3d;
    localparam logic [7:0] port4_phy_control = 8'h4d;
    localparam logic [7:0] port5_phy_control = 8'h5d;
    localparam logic [7:0] port_stride = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int indicator_blank_bit = 7;
    localparam int tx_disable_bit = 6;
    localparam int negotiation_restart_bit = 5;
    localparam int fiber_reserved_bit = 4;
    localparam int power_down_bit = 3;
    localparam int auto_crossover_disable_bit = 2;
    localparam int fixed_straight_select_bit = 1;
    localparam int mac_loop_test_bit = 0;

    localparam logic [7:0] control_reset = 8'h00;

    // ------------------------------------------------------------
    // Bus carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
        logic hready;
    } ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } ahb_rsp_t;

    localparam logic [1:0] htrans_nonseq = 2'h2;
    localparam logic [1:0] htrans_seq = 2'h3;

    // Per-port controls handed to the PHY and MAC
    typedef struct packed {
        logic tx_disable;
        logic negotiation_restart;
        logic power_down;
        logic auto_crossover_enable;
        logic fixed_straight_select;
        logic mac_loop_test;
    } port_phy_t;

endpackage

// >>> port_phy_control_bits.sv
// Per-port PHY control register bank of a five-port switch.
// Assumes AHB-Lite single word transfers; PHY, MAC and the forwarding
// path sit outside and consume the per-port control outputs.
//
// Overview of operation
// [R1] Indicator-off bit 7 set drives the port's indicator pins high; the bank drives only port_indicator_pin_zero.
// [R2] Transmit-disable bit 6 set disables the port's transmitter.
// [R3] Writing one to bit 5 restarts negotiation; it self-clears to 0.
// [R4] Bit 3 set powers the port down; it resets to zero.
// [R5] Bit 2 set disables automatic crossover; zero enables it.
// [R6] With crossover off, bit 1 one forces MDI and zero forces MDI-X.
// [R7] Loopback bit 0 set loops frames back through the port's MAC.
// [R8] Frames from a monitor port pass the looped MAC and leave again.
// [R9] Loopback control exists at indices 29, 45, 61, 77 and 93.
`timescale 1ns/1ps
`default_nettype none

module port_phy_control_bits
    import port_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire port_ctrl_pkg::ahb_req_t ahb_req,
    input wire logic [31:0] hwdata,
    output var port_ctrl_pkg::ahb_rsp_t ahb_rsp,
    output logic [num_ports-1:0] port_indicator_pin_zero,
    output var port_ctrl_pkg::port_phy_t [num_ports-1:0] port_phy,
    output logic [num_ports-1:0] loop_active
);
    import port_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Returns the port number 0..4 and a hit flag for a byte address
    function automatic logic [3:0] decode(input logic [31:0] addr);
        logic [7:0] idx;
        logic [3:0] res;
        idx = addr[9:2];
        res = 4'h0;
        if (addr[31:10] == 22'h0 && addr[1:0] == 2'h0) begin
            for (int p = 0; p < num_ports; p++) begin
                if (idx == port1_phy_control + 8'(p) * port_stride) begin
                    res = {1'b1, 3'(p)};
                end
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Bus phase tracking
    // ------------------------------------------------------------
    logic wr_pend, next_wr_pend;
    logic [3:0] wr_sel, next_wr_sel;
    logic [31:0] rdata, next_rdata;
    logic [7:0] ctrl [num_ports];
    logic [7:0] next_ctrl [num_ports];
    // Restart goes straight to the output flop, so no extra stage
    logic [num_ports-1:0] next_restart;

    logic accept;
    logic [3:0] hit;

    always_comb begin
        accept = ahb_req.hsel && ahb_req.hready &&
                 (ahb_req.htrans == htrans_nonseq ||
                  ahb_req.htrans == htrans_seq);
        hit = decode(ahb_req.haddr);
        next_wr_pend = accept && ahb_req.hwrite;
        next_wr_sel = hit;
        next_rdata = 32'h0;
        if (accept && !ahb_req.hwrite && hit[3]) begin
            // Restart bit always reads zero because it self-clears
            next_rdata = {24'h0, ctrl[hit[2:0]]};  // see [R3]
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_comb begin
        for (int p = 0; p < num_ports; p++) begin
            next_ctrl[p] = ctrl[p];
            next_restart[p] = 1'b0;
            if (wr_pend && wr_sel[3] && wr_sel[2:0] == 3'(p)) begin
                next_ctrl[p] = hwdata[7:0];
                // Restart is a one-cycle strobe, never stored
                next_restart[p] = hwdata[negotiation_restart_bit]; // see [R3]
            end
            next_ctrl[p][negotiation_restart_bit] = 1'b0;  // see [R3]
            next_ctrl[p][fiber_reserved_bit] = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_pend <= 1'b0;
            wr_sel <= 4'h0;
            rdata <= 32'h0;
            for (int p = 0; p < num_ports; p++) begin
                ctrl[p] <= control_reset;
            end
        end else begin
            wr_pend <= next_wr_pend;
            wr_sel <= next_wr_sel;
            rdata <= next_rdata;
            for (int p = 0; p < num_ports; p++) begin
                ctrl[p] <= next_ctrl[p];
            end
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    logic [num_ports-1:0] next_pins;
    port_phy_t [num_ports-1:0] next_phy;
    logic [num_ports-1:0] next_loop;

    always_comb begin
        for (int p = 0; p < num_ports; p++) begin
            // High on the pin turns the indicator off
            next_pins[p] = next_ctrl[p][indicator_blank_bit];  // see [R1]
            next_phy[p].tx_disable =
                next_ctrl[p][tx_disable_bit];  // see [R2]
            next_phy[p].negotiation_restart = next_restart[p];  // see [R3]
            next_phy[p].power_down =
                next_ctrl[p][power_down_bit];  // see [R4]
            next_phy[p].auto_crossover_enable =
                !next_ctrl[p][auto_crossover_disable_bit];  // see [R5]
            // Only meaningful while automatic crossover is off
            next_phy[p].fixed_straight_select =
                next_ctrl[p][fixed_straight_select_bit];  // see [R6]
            next_phy[p].mac_loop_test =
                next_ctrl[p][mac_loop_test_bit];  // see [R7] [R9]
            // The forwarding path steers monitor-port frames through
            // this MAC while the flag stands
            next_loop[p] = next_ctrl[p][mac_loop_test_bit];  // see [R8]
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            port_indicator_pin_zero <= '0;
            port_phy <= '0;
            loop_active <= '0;
            ahb_rsp <= '0;
        end else begin
            port_indicator_pin_zero <= next_pins;
            port_phy <= next_phy;
            loop_active <= next_loop;
            ahb_rsp <= '{hrdata: next_rdata, hreadyout: 1'b1, hresp: 1'b0};
        end
    end

endmodule

`default_nettype wire

// >>> port_ctrl_assertions.sv
// Checker for the port control register bank.
// Sees only the top ports; port 1 stands for all ports.
`timescale 1ns/1ps
`default_nettype none
module port_ctrl_checker
    import port_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire port_ctrl_pkg::ahb_req_t ahb_req,
    input wire logic [31:0] hwdata,
    input wire port_ctrl_pkg::ahb_rsp_t ahb_rsp,
    input wire logic [num_ports-1:0] port_indicator_pin_zero,
    input wire port_ctrl_pkg::port_phy_t [num_ports-1:0] port_phy,
    input wire logic [num_ports-1:0] loop_active
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence wr1;
        ahb_req.hsel && ahb_req.hready && ahb_req.hwrite
            && ahb_req.htrans == htrans_nonseq && ahb_req.haddr == 32'h74
            ##1 1'b1;
    endsequence
    property wr_bit(int b, logic seen);
        wr1 |=> seen == $past(hwdata[b]);
    endproperty
    indicator_write_a: assert property (wr_bit(7, port_indicator_pin_zero[0]))
        else $error("indicator pin wrong");
    tx_write_a: assert property (wr_bit(6, port_phy[0].tx_disable))
        else $error("tx disable wrong");
    restart_pulse_a: assert property (port_phy[0].negotiation_restart |=>
        !port_phy[0].negotiation_restart) else $error("restart held");
    restart_write_a: assert property (wr_bit(5,
        port_phy[0].negotiation_restart)) else $error("restart missed");
    power_write_a: assert property (wr_bit(3, port_phy[0].power_down))
        else $error("power down wrong");
    cross_write_a: assert property (wr_bit(2,
        !port_phy[0].auto_crossover_enable)) else $error("crossover");
    straight_write_a: assert property (wr_bit(1,
        port_phy[0].fixed_straight_select)) else $error("straight");
    loop_write_a: assert property (wr_bit(0, port_phy[0].mac_loop_test))
        else $error("loop bit wrong");
    loop_level_a: assert property (wr_bit(0, loop_active[0]))
        else $error("loop level wrong");
endmodule
bind port_phy_control_bits port_ctrl_checker u_chk (.core_clk(core_clk),
    .reset(reset), .ahb_req(ahb_req), .hwdata(hwdata), .ahb_rsp(ahb_rsp),
    .port_indicator_pin_zero(port_indicator_pin_zero),
    .port_phy(port_phy), .loop_active(loop_active));
`default_nettype wire

// >>> port_phy_control_bits_test.sv
// Self-checking bench for the port control register bank.
// The bench is the AHB-Lite master; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module port_phy_control_bits_test;
    import port_ctrl_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    ahb_req_t req = '{hsize: 3'h2, default: '0};
    logic [31:0] hwdata = '0;
    ahb_rsp_t rsp;
    logic [num_ports-1:0] pins;
    logic [num_ports-1:0] loops;
    port_phy_t [num_ports-1:0] phy;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [7:0] model [num_ports];
    port_phy_control_bits u_dut (.core_clk(core_clk), .reset(reset),
        .ahb_req({req[39:1], rsp.hreadyout}), .hwdata(hwdata),
        .ahb_rsp(rsp), .port_indicator_pin_zero(pins), .port_phy(phy),
        .loop_active(loops));
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // --------------------------------------------------------------
    // Hang guard: a full run needs under 2000 cycles
    // --------------------------------------------------------------
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic xfer(input logic [31:0] a, input logic w,
                        input logic [7:0] d, output logic [31:0] r);
        req.haddr <= a;
        req.htrans <= htrans_nonseq;
        req.hwrite <= w;
        req.hsel <= 1'b1;
        do @(posedge core_clk); while (rsp.hreadyout !== 1'b1);
        req.htrans <= 2'h0;
        req.hsel <= 1'b0;
        hwdata <= {24'($urandom()), d};
        do @(posedge core_clk); while (rsp.hreadyout !== 1'b1);
        r = rsp.hrdata;
    endtask
    task automatic check_port(int p, logic [7:0] v);
        check("outputs", {pins[p], phy[p], loops[p]},
              {v[7:5], v[3], ~v[2], v[1:0], v[0]});
    endtask
    initial begin
        logic [31:0] r;
        logic [7:0] v;
        int p;
        void'($urandom(54));
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        for (p = 0; p < num_ports; p++) begin
            xfer(32'(port1_phy_control + port_stride * p) << 2, 0, 0, r);
            check("reset read", r, 0);
            model[p] = 8'h00;
        end
        // Walk each bit first, then random values on random ports
        for (int i = 0; i < 150; i++) begin
            p = $urandom_range(num_ports - 1);
            v = (i < 8) ? 8'h01 << i : 8'($urandom());
            xfer(32'(port1_phy_control + port_stride * p) << 2, 1, v, r);
            model[p] = v & 8'hdf;
            #1 check_port(p, v);
            xfer(32'(port1_phy_control + port_stride * p) << 2, 0, 0, r);
            check("read back", r, {24'h0, model[p] & 8'hcf});
            #1 check_port(p, model[p]);
        end
        // Unmapped word between ports must change nothing
        xfer(32'h78, 1, 8'hff, r);
        xfer(32'h78, 0, 0, r);
        check("unmapped read", r, 0);
        #1 for (p = 0; p < num_ports; p++) check_port(p, model[p]);
        complete_run();
    end
endmodule
`default_nettype wire
